/* logic/adc_control_pkg.sv */
// Shared constants and types for the converter control block.
// Assumes a single 250 MHz clock; the block is the only user.
package adc_control_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Result and timing
  localparam int RESULT_WIDTH = 12;
  localparam logic [3:0] MSB_INDEX = 4'hb;
  localparam int CLOCK_PERIOD_NS = 4;
  // Time given to each bit decision of the self-timed sequencer
  localparam int BIT_TIME_NS = 600;
  localparam int BIT_CYCLES =
    (BIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Reference settling after leaving sleep
  localparam int REF_SETTLE_US = 4200;
  localparam int REF_SETTLE_CYCLES =
    REF_SETTLE_US * 1000 / CLOCK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int ADDR_WIDTH = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] RESULT_OFFSET = 4'h8;
  localparam int CTRL_TWO_BYTE_BIT = 0;
  localparam logic CTRL_TWO_BYTE_RESET = 1'b0;
  localparam int STATUS_BUSY_N_BIT = 0;
  localparam int STATUS_REF_READY_BIT = 1;
  localparam int STATUS_NAP_BIT = 2;
  localparam int STATUS_SLEEP_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // Data line patterns
  localparam logic [11:0] ALL_LINES = 12'hfff;
  localparam logic [11:0] BYTE_LINES = 12'h0ff;
  localparam logic [11:0] NO_LINES = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_type;

  // Three-state data lines: level and per-line drive enable
  typedef struct packed {
    logic [11:0] value;
    logic [11:0] enable;
  } data_pins_type;

endpackage

/* logic/sar_adc_parallel_host_control.sv */
// Control and parallel readout of a 12-bit successive approximation
// converter, with a small AXI4-Lite register slave.
// Assumes host pins are synchronous to clock and that an analog
// comparator answers comparator_above for the trial code on dac_trial.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

module sar_adc_parallel_host_control #(
  parameter int reference_settle_cycles =
    adc_control_pkg::REF_SETTLE_CYCLES,
  parameter int bit_cycles = adc_control_pkg::BIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic conversion_start_n,
  input wire logic read_strobe_n,
  input wire logic high_byte_select,
  input wire logic sleep_n,
  input wire logic light_powerdown_n,
  input wire logic comparator_above,
  output logic [11:0] dac_trial,
  output logic busy_n,
  output logic reference_ready,
  output logic light_powerdown_active,
  output adc_control_pkg::data_pins_type data_lines,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SETTLE_WIDTH = $clog2(reference_settle_cycles + 1);
  localparam int BIT_COUNT_WIDTH = $clog2(bit_cycles + 1);
  localparam logic [SETTLE_WIDTH-1:0] SETTLE_LAST =
    SETTLE_WIDTH'(reference_settle_cycles - 1);
  localparam logic [BIT_COUNT_WIDTH-1:0] BIT_LAST =
    BIT_COUNT_WIDTH'(bit_cycles - 1);

  adc_control_pkg::conv_state_type state;
  adc_control_pkg::conv_state_type next_state;
  logic start_prev;
  logic [11:0] approximation_register;
  logic [11:0] result_latch;
  logic [3:0] bit_index;
  logic [BIT_COUNT_WIDTH-1:0] bit_count;
  logic [SETTLE_WIDTH-1:0] settle_count;
  logic two_byte_mode;

  ////////////////////////////////////////////////////////////////////////
  // Start detection and sequencing terms
  wire converting = (state == adc_control_pkg::ST_CONVERT);
  wire start_edge = start_prev & ~conversion_start_n
    & ~chip_select_n;
  // Starts are dropped while powered down, not queued for later
  wire start_accept = start_edge & ~converting & sleep_n
    & ~light_powerdown_active;
  wire bit_tick = converting & (bit_count == BIT_LAST);
  wire last_bit = (bit_index == 4'h0);
  wire finish = bit_tick & last_bit;
  wire [11:0] trial_bit = 12'h001 << bit_index;
  wire [11:0] trial_code = approximation_register | trial_bit;
  wire [11:0] decided_code =
    comparator_above ? trial_code : approximation_register;

  // Nap only exists in the two-byte variant
  assign light_powerdown_active =
    two_byte_mode & ~light_powerdown_n;
  assign dac_trial = trial_code;
  assign busy_n = ~converting;

  // Next state: sleep aborts a conversion, nothing else can
  always_comb begin
    next_state = state;
    case (state)
      adc_control_pkg::ST_IDLE: begin
        if (start_accept) begin
          next_state = adc_control_pkg::ST_CONVERT;
        end
      end
      adc_control_pkg::ST_CONVERT: begin
        if (finish) begin
          next_state = adc_control_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adc_control_pkg::ST_IDLE;
      end
    endcase
    if (!sleep_n) begin
      next_state = adc_control_pkg::ST_IDLE;
    end
  end

  // State register and previous start level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= adc_control_pkg::ST_IDLE;
      start_prev <= 1'b1;
    end else begin
      state <= next_state;
      start_prev <= conversion_start_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit timer: one enable pulse per decision
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_count <= '0;
    end else if (!converting || bit_tick) begin
      bit_count <= '0;
    end else begin
      bit_count <= bit_count + BIT_COUNT_WIDTH'(1);
    end
  end

  // Successive approximation, MSB first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      approximation_register <= 12'h000;
      bit_index <= adc_control_pkg::MSB_INDEX;
    end else if (start_accept) begin
      approximation_register <= 12'h000;
      bit_index <= adc_control_pkg::MSB_INDEX;
    end else if (bit_tick) begin
      approximation_register <= decided_code;
      bit_index <= bit_index - 4'h1;
    end
  end

  // Output latches load on the edge that ends busy, so data and busy change together
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_latch <= 12'h000;
    end else if (finish) begin
      result_latch <= decided_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference settling after sleep
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle_count <= '0;
      reference_ready <= 1'b0;
    end else if (!sleep_n) begin
      settle_count <= '0;
      reference_ready <= 1'b0;
    end else if (!reference_ready) begin
      if (settle_count == SETTLE_LAST) begin
        reference_ready <= 1'b1;
      end else begin
        settle_count <= settle_count + SETTLE_WIDTH'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Three-state data lines, read from the latch only
  wire read_enable = ~read_strobe_n & ~chip_select_n;
  // Codes leave the latch unaltered: straight or offset binary
  wire [7:0] byte_value = high_byte_select
    ? {4'h0, result_latch[11:8]}
    : result_latch[7:0];
  assign data_lines.value = two_byte_mode
    ? {4'h0, byte_value}
    : result_latch;
  assign data_lines.enable = !read_enable ? adc_control_pkg::NO_LINES
    : two_byte_mode ? adc_control_pkg::BYTE_LINES
    : adc_control_pkg::ALL_LINES;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire do_read = s_axi_arvalid & s_axi_arready;
  wire write_ctrl = (aw_addr == adc_control_pkg::CTRL_OFFSET);
  wire write_known = write_ctrl
    | (aw_addr == adc_control_pkg::STATUS_OFFSET)
    | (aw_addr == adc_control_pkg::RESULT_OFFSET);

  // Read decode
  logic [31:0] read_value;
  logic read_known;
  always_comb begin
    read_value = 32'h0000_0000;
    read_known = 1'b1;
    if (s_axi_araddr == adc_control_pkg::CTRL_OFFSET) begin
      read_value[adc_control_pkg::CTRL_TWO_BYTE_BIT] = two_byte_mode;
    end else if (s_axi_araddr == adc_control_pkg::STATUS_OFFSET) begin
      read_value[adc_control_pkg::STATUS_BUSY_N_BIT] = busy_n;
      read_value[adc_control_pkg::STATUS_REF_READY_BIT] = reference_ready;
      read_value[adc_control_pkg::STATUS_NAP_BIT] = light_powerdown_active;
      read_value[adc_control_pkg::STATUS_SLEEP_BIT] = ~sleep_n;
    end else if (s_axi_araddr == adc_control_pkg::RESULT_OFFSET) begin
      read_value[11:0] = result_latch;
    end else begin
      read_known = 1'b0;
    end
  end

  // Write channel capture and response
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adc_control_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_known ? adc_control_pkg::RESP_OKAY
          : adc_control_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register: format changes take effect on the next read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      two_byte_mode <= adc_control_pkg::CTRL_TWO_BYTE_RESET;
    end else if (do_write && write_ctrl && w_strb[0]) begin
      two_byte_mode <= w_data[adc_control_pkg::CTRL_TWO_BYTE_BIT];
    end
  end

  // Read channel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adc_control_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= read_known ? adc_control_pkg::RESP_OKAY
        : adc_control_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* test/adc_control_sva.sv */
// Checker for the converter pins of the top module.
// Assumes it is bound into that module and shares its counts.
`timescale 1ns/1ns
module adc_control_sva #(
  parameter int reference_settle_cycles = 20,
  parameter int bit_cycles = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic conversion_start_n,
  input wire logic read_strobe_n,
  input wire logic high_byte_select,
  input wire logic sleep_n,
  input wire logic light_powerdown_active,
  input wire logic comparator_above,
  input wire logic [11:0] dac_trial,
  input wire logic busy_n,
  input wire logic reference_ready,
  input wire adc_control_pkg::data_pins_type data_lines
);
  localparam int hold = 12 * bit_cycles - 1;
  localparam int ready_max = reference_settle_cycles + 4;
  wire rd_on = !read_strobe_n && !chip_select_n;
  wire [11:0] en = data_lines.enable;
  wire [11:0] val = data_lines.value;
  // All checks on the rising edge, quiet in reset
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_start_taken: assert property (
    $past(conversion_start_n) && !conversion_start_n && !chip_select_n
    && sleep_n && busy_n && !light_powerdown_active |=> !busy_n)
    else $error("qualified start not taken");
  a_cs_ignore: assert property (
    chip_select_n && busy_n |=> busy_n) else $error("start with cs high");
  a_bus_float: assert property (
    !rd_on |-> en == 12'h000) else $error("lines driven without read");
  a_busy_len: assert property (
    $fell(busy_n) |-> (!busy_n throughout ##hold 1'b1) ##1 busy_n)
    else $error("busy low time wrong");
  a_trial_clear: assert property (
    $fell(busy_n) |-> dac_trial == 12'h800) else $error("trial not cleared");
  a_msb_first: assert property (
    $fell(busy_n) ##bit_cycles 1'b1 |-> dac_trial[10:0] == 11'h400
    && dac_trial[11] == $past(comparator_above)) else $error("bit order");
  a_result_rise: assert property (
    $rose(busy_n) && sleep_n && en == 12'hfff |->
    val == {$past(dac_trial[11:1]), $past(comparator_above)})
    else $error("result late at busy rise");
  a_sleep_ready: assert property (
    !sleep_n |=> !reference_ready) else $error("ready high in sleep");
  a_ready_wait: assert property (
    $rose(sleep_n) |-> !reference_ready [*8] ##[1:ready_max] reference_ready)
    else $error("ready timing wrong");
  a_high_byte: assert property (
    rd_on && en == 12'h0ff |-> val[11:8] == 4'h0
    && (!high_byte_select || val[7:4] == 4'h0)) else $error("byte format");
  c_conv: cover property ($rose(busy_n));
  c_ready: cover property ($rose(reference_ready));
  c_high: cover property (rd_on && high_byte_select && en == 12'h0ff);
endmodule
bind sar_adc_parallel_host_control adc_control_sva #(
  .reference_settle_cycles(reference_settle_cycles),
  .bit_cycles(bit_cycles)) chk (.clock, .rst, .chip_select_n,
  .conversion_start_n, .read_strobe_n, .high_byte_select, .sleep_n,
  .light_powerdown_active, .comparator_above, .dac_trial, .busy_n,
  .reference_ready, .data_lines);

/* test/analog_front.sv */
// Comparator stand-in for the analog input stage of the converter.
// Assumes the bench holds the input level as a 12-bit code.
`timescale 1ns/1ns
module analog_front (
  input wire logic [11:0] dac_trial,
  input wire logic [11:0] sample_code,
  output logic comparator_above
);
  // High while the trial does not exceed the held input, so the
  // search lands on sample_code; settling is taken as instant
  assign comparator_above = dac_trial <= sample_code;
endmodule

/* test/sar_adc_parallel_host_control_tb.sv */
// Self-checking bench: host pins, AXI4-Lite master, result model.
// Assumes shortened counts; the comparator model sits in far.
`timescale 1ns/1ns
module sar_adc_parallel_host_control_tb;
  localparam int bc = 2;
  localparam int rs = 20;
  logic clock = 0, rst = 1, chip_select_n = 1, conversion_start_n = 1;
  logic read_strobe_n = 1, high_byte_select = 0, sleep_n = 1;
  logic light_powerdown_n = 1, comparator_above, busy_n, reference_ready;
  logic light_powerdown_active, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [11:0] dac_trial, sample_code = 12'h000;
  adc_control_pkg::data_pins_type data_lines;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int bad_count = 0, total_checks = 0, model_result = 0, two_byte = 0;
  int codes[$];
  sar_adc_parallel_host_control #(.reference_settle_cycles(rs),
    .bit_cycles(bc)) uut (.clock, .rst, .chip_select_n, .conversion_start_n,
    .read_strobe_n, .high_byte_select, .sleep_n, .light_powerdown_n,
    .comparator_above, .dac_trial, .busy_n, .reference_ready,
    .light_powerdown_active, .data_lines, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  analog_front far (.dac_trial, .sample_code, .comparator_above);
  // Free-running clock and a hang guard
  initial forever #2 clock = ~clock;
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Model of the pins: word mode, or low/high byte in two-byte mode
  function automatic logic [11:0] ev(logic hb);
    if (two_byte == 0) return model_result[11:0];
    return hb ? {8'h00, model_result[11:8]} : {4'h0, model_result[7:0]};
  endfunction
  // Readies are looked at before the edge, so the release lands on it
  task automatic axw(logic [3:0] a, logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end while (!b);
    s_axi_bready <= 0;
    @(posedge clock); // Idle edge keeps back-to-back calls apart
  endtask
  task automatic axr(logic [3:0] a);
    logic ar, r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge clock);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ar) s_axi_arvalid <= 0;
    end while (!r);
    s_axi_rready <= 0;
    @(posedge clock); // Idle edge keeps back-to-back calls apart
  endtask
  // Byte select settles a cycle before the strobe and holds past it
  task automatic pins(logic hb);
    high_byte_select <= hb;
    @(posedge clock);
    read_strobe_n <= 0;
    @(posedge clock) #1;
    check("pins", data_lines.value, ev(hb));
    check("drive", data_lines.enable,
      two_byte ? 12'h0ff : 12'hfff);
    @(posedge clock);
    read_strobe_n <= 1;
    @(posedge clock) #1;
    check("float", data_lines.enable, 12'h000);
    @(posedge clock);
  endtask
  // Start, refused restart, read while busy, then the new result
  task automatic convert(logic [11:0] code);
    int n;
    sample_code <= code;
    conversion_start_n <= 0;
    @(posedge clock);
    conversion_start_n <= 1;
    @(posedge clock);
    conversion_start_n <= 0;
    high_byte_select <= 0;
    @(posedge clock);
    conversion_start_n <= 1;
    read_strobe_n <= 0;
    @(posedge clock) #1;
    check("busy", busy_n, 0);
    check("old result", data_lines.value, ev(0));
    for (n = 0; n < 100 && busy_n !== 1; n++) @(posedge clock) #1;
    check("conv time", n, 12 * bc - 3);
    model_result = code;
    check("new result", data_lines.value, ev(0));
    @(posedge clock);
    read_strobe_n <= 1;
    axr(adc_control_pkg::RESULT_OFFSET);
    check("result reg", rd, model_result);
    repeat (500) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(41));
    codes = '{12'hfff, 12'h000};
    repeat (4) codes.push_back($urandom % 4096);
    repeat (3) @(posedge clock);
    rst <= 0;
    chip_select_n <= 0;
    @(posedge clock);
    axr(adc_control_pkg::STATUS_OFFSET);
    check("status", rd, 32'h1);
    axr(4'hc);
    check("bad rresp", resp, adc_control_pkg::RESP_SLVERR);
    axw(4'hc, 32'h1);
    check("bad bresp", resp, adc_control_pkg::RESP_SLVERR);
    axw(adc_control_pkg::STATUS_OFFSET, 32'hf);
    check("ro bresp", resp, adc_control_pkg::RESP_OKAY);
    // Let the reference settle first so the sleep drop is visible
    repeat (rs) @(posedge clock);
    #1 check("ready at reset", reference_ready, 1);
    @(posedge clock);
    sleep_n <= 0;
    @(posedge clock) #1;
    check("sleep", reference_ready, 0);
    @(posedge clock);
    axr(adc_control_pkg::STATUS_OFFSET);
    check("sleep status", rd, 32'h9);
    sleep_n <= 1;
    repeat (8) @(posedge clock);
    #1 check("settling", reference_ready, 0);
    repeat (rs) @(posedge clock);
    #1 check("settled", reference_ready, 1);
    @(posedge clock);
    chip_select_n <= 1;
    conversion_start_n <= 0;
    read_strobe_n <= 0;
    @(posedge clock);
    conversion_start_n <= 1;
    @(posedge clock) #1;
    check("cs high", {busy_n, data_lines.enable}, 13'h1000);
    @(posedge clock);
    chip_select_n <= 0;
    read_strobe_n <= 1;
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        axw(adc_control_pkg::CTRL_OFFSET, 32'h1);
        axr(adc_control_pkg::CTRL_OFFSET);
        check("ctrl", rd, 32'h1);
        two_byte = 1;
        light_powerdown_n <= 0;
        conversion_start_n <= 0;
        @(posedge clock);
        conversion_start_n <= 1;
        @(posedge clock) #1;
        check("nap", {light_powerdown_active, busy_n}, 2'b11);
        @(posedge clock);
        axr(adc_control_pkg::STATUS_OFFSET);
        check("nap status", rd, 32'h7);
        light_powerdown_n <= 1;
        repeat (155) @(posedge clock);
      end
      foreach (codes[i]) begin
        convert(codes[i][11:0]);
        pins(1);
        pins(0);
      end
    end
    summarize();
  end
endmodule
